//--- osp_ctrl.sv
module osp_ctrl (
	input wire logic    mclk,
	input wire logic    rstn,
	osp_if.host         bus,
	input wire logic    start,
	input wire logic    withDelay,
	input wire logic [15:0] delayCnt,
	input wire logic [15:0] widthCnt,
	input wire logic    trigIn,
	output logic        busy,
	output logic        done,
	output logic        pulseSeen
);
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_SETUP = 7'h02,
		S_ARMED = 7'h04,
		S_READ  = 7'h08,
		S_SERVE = 7'h10,
		S_WAIT  = 7'h20,
		S_END   = 7'h40
	} osp_hst_state_t;

	typedef struct packed {
		osp_hst_state_t st;
		logic [2:0]     step;
		logic           noDly;
		logic [15:0]    dly;
		logic [15:0]    wid;
		logic [15:0]    cap;
		logic           wr;
		logic           rd;
		logic [3:0]     addr;
		logic [15:0]    wdata;
		logic           trig;
		logic           busy;
		logic           done;
		logic           pulse;
	} osp_hst_t;

	typedef struct packed {
		logic        last;
		logic [3:0]  addr;
		logic [15:0] data;
	} osp_cmd_t;

	osp_hst_t s_q;
	osp_hst_t s_d;
	osp_cmd_t cmd;

	// ---------------------------------------------------------
	// setup sequence: enable, stop, mode, toggle control, irq, start
	// ---------------------------------------------------------
	function automatic osp_cmd_t setupCmd(input logic [2:0] k, input logic nd);
		setupCmd = '0;
		unique case (k)
			3'h0: setupCmd = {1'b0, osp_pkg::A_ENABLE, 16'h0001};
			3'h1: setupCmd = {1'b0, osp_pkg::A_RUN, 16'h0000};
			3'h2: setupCmd = {1'b0, osp_pkg::A_MODE, osp_pkg::MODE_ONESHOT};
			3'h3: setupCmd = {1'b0, osp_pkg::A_TOGCTL,
				16'(nd) << osp_pkg::T_ENCAP | 16'(osp_pkg::DC_CLEAR)};
			3'h4: setupCmd = {1'b0, osp_pkg::A_IRQEN, 16'h0001};
			default: setupCmd = {1'b1, osp_pkg::A_RUN, 16'h0001};
		endcase
	endfunction

	// ---------------------------------------------------------
	// capture service: compares, toggles, mask, match irq
	// ---------------------------------------------------------
	function automatic osp_cmd_t serveCmd(input logic [2:0] k, input logic nd,
		input logic [15:0] c, input logic [15:0] d, input logic [15:0] p);
		logic [15:0] dEff;
		logic [15:0] tog;
		dEff = nd ? 16'h0000 : d;
		tog = (16'h0001 << osp_pkg::T_EN1) | 16'(osp_pkg::DC_KEEP);
		if (!nd) begin
			tog = tog | (16'h0001 << osp_pkg::T_EN0);
		end
		serveCmd = '0;
		unique case (k)
			3'h0: serveCmd = {1'b0, osp_pkg::A_CMP0, 16'(c + dEff)};
			3'h1: serveCmd = {1'b0, osp_pkg::A_CMP1, 16'(c + dEff + p)};
			3'h2: serveCmd = {1'b0, osp_pkg::A_TOGCTL, tog};
			3'h3: serveCmd = {1'b0, osp_pkg::A_IMASK, osp_pkg::IMASK_ONLY1};
			default: serveCmd = {1'b1, osp_pkg::A_IRQEN, 16'h0003};
		endcase
	endfunction

	// ---------------------------------------------------------
	// match service: disarm toggles, drop match irq
	// ---------------------------------------------------------
	function automatic osp_cmd_t endCmd(input logic [2:0] k);
		endCmd = '0;
		if (k == 3'h0) begin
			endCmd = {1'b0, osp_pkg::A_TOGCTL, 16'(osp_pkg::DC_KEEP)};
		end else begin
			endCmd = {1'b1, osp_pkg::A_IRQEN, 16'h0001};
		end
	endfunction

	always_comb begin
		s_d = s_q;
		cmd = '0;
		s_d.wr = 1'b0;
		s_d.rd = 1'b0;
		s_d.done = 1'b0;
		s_d.trig = trigIn;
		unique case (s_q.st)
			S_IDLE: begin
				if (start) begin
					s_d.noDly = !withDelay;
					s_d.dly = delayCnt;
					s_d.wid = widthCnt;
					s_d.step = '0;
					s_d.busy = 1'b1;
					s_d.st = S_SETUP;
				end
			end
			S_SETUP: begin
				cmd = setupCmd(s_q.step, s_q.noDly);
				s_d.wr = 1'b1;
				s_d.addr = cmd.addr;
				s_d.wdata = cmd.data;
				s_d.step = s_q.step + 3'h1;
				if (cmd.last) begin
					s_d.step = '0;
					s_d.st = S_ARMED;
				end
			end
			S_ARMED: begin
				if (bus.capIrq) begin
					s_d.rd = 1'b1;
					s_d.addr = osp_pkg::A_CAP0;
					s_d.step = '0;
					s_d.st = S_READ;
				end
			end
			S_READ: begin
				s_d.step = s_q.step + 3'h1;
				if (s_q.step == 3'(osp_pkg::RD_WAIT - 2)) begin
					s_d.cap = bus.regRdata;
					s_d.step = '0;
					s_d.st = S_SERVE;
				end
			end
			S_SERVE: begin
				cmd = serveCmd(s_q.step, s_q.noDly, s_q.cap, s_q.dly, s_q.wid);
				s_d.wr = 1'b1;
				s_d.addr = cmd.addr;
				s_d.wdata = cmd.data;
				s_d.step = s_q.step + 3'h1;
				if (cmd.last) begin
					s_d.step = '0;
					s_d.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (bus.matchIrq) begin
					s_d.st = S_END;
				end
			end
			S_END: begin
				cmd = endCmd(s_q.step);
				s_d.wr = 1'b1;
				s_d.addr = cmd.addr;
				s_d.wdata = cmd.data;
				s_d.step = s_q.step + 3'h1;
				if (cmd.last) begin
					s_d.step = '0;
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.st = S_IDLE;
				end
			end
			default: s_d.st = S_IDLE;
		endcase
		s_d.pulse = bus.pulseOut;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= S_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.regWr    = s_q.wr;
	assign bus.regRd    = s_q.rd;
	assign bus.regAddr  = s_q.addr;
	assign bus.regWdata = s_q.wdata;
	assign bus.extTrig  = s_q.trig;
	assign busy         = s_q.busy;
	assign done         = s_q.done;
	assign pulseSeen    = s_q.pulse;
endmodule // osp_ctrl

//--- osp_pkg.sv
package osp_pkg;
	// ---------------------------------------------------------
	// register indices
	// ---------------------------------------------------------
	localparam logic [3:0] A_ENABLE = 4'h0;
	localparam logic [3:0] A_RUN    = 4'h1;
	localparam logic [3:0] A_MODE   = 4'h2;
	localparam logic [3:0] A_TOGCTL = 4'h3;
	localparam logic [3:0] A_IMASK  = 4'h4;
	localparam logic [3:0] A_IRQEN  = 4'h5;
	localparam logic [3:0] A_CMP0   = 4'h6;
	localparam logic [3:0] A_CMP1   = 4'h7;
	localparam logic [3:0] A_CAP0   = 4'h8;
	localparam logic [3:0] A_COUNT  = 4'h9;
	// ---------------------------------------------------------
	// field positions
	// ---------------------------------------------------------
	localparam int M_CLKSEL = 0;
	localparam int M_CLE    = 2;
	localparam int M_CAPM   = 3;
	localparam int T_DC     = 0;
	localparam int T_EN0    = 2;
	localparam int T_EN1    = 3;
	localparam int T_ENCAP  = 4;
	localparam int T_FFVAL  = 5;
	localparam int I_MSK0   = 0;
	localparam int I_MSK1   = 1;
	localparam int I_MSKOV  = 2;
	localparam int E_CAP    = 0;
	localparam int E_MATCH  = 1;
	// ---------------------------------------------------------
	// field codes and values
	// ---------------------------------------------------------
	localparam logic [1:0] DC_INVERT = 2'h0;
	localparam logic [1:0] DC_SET    = 2'h1;
	localparam logic [1:0] DC_CLEAR  = 2'h2;
	localparam logic [1:0] DC_KEEP   = 2'h3;
	localparam logic [1:0] CLK_EXT   = 2'h0;
	localparam logic [1:0] CLK_TAP1  = 2'h1;
	localparam logic [1:0] CAPM_RISE = 2'h1;
	localparam logic [15:0] MODE_ONESHOT = 16'h0009;
	localparam logic [15:0] IMASK_ONLY1  = 16'h0005;
	localparam logic [2:0]  IMASK_RST    = 3'h7;
	// ---------------------------------------------------------
	// prescaler taps (log2 of divide ratio)
	// ---------------------------------------------------------
	localparam int TAP1_LOG2 = 1;
	localparam int TAP2_LOG2 = 3;
	localparam int TAP3_LOG2 = 5;
	localparam int PRE_W     = 5;
	localparam int RD_WAIT   = 3;
endpackage

//--- osp_if.sv
interface osp_if;
	logic        regWr;
	logic        regRd;
	logic [3:0]  regAddr;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic        capIrq;
	logic        matchIrq;
	logic        extTrig;
	logic        pulseOut;
	modport dev (
		input  regWr, regRd, regAddr, regWdata, extTrig,
		output regRdata, capIrq, matchIrq, pulseOut
	);
	modport host (
		output regWr, regRd, regAddr, regWdata, extTrig,
		input  regRdata, capIrq, matchIrq, pulseOut
	);
endinterface

//--- osp_timer.sv
module osp_timer (
	input wire logic mclk,
	input wire logic rstn,
	osp_if.dev       bus,
	output logic     running,
	output logic [15:0] count
);
	// ---------------------------------------------------------
	// state
	// ---------------------------------------------------------
	typedef struct packed {
		logic              en;
		logic              run;
		logic [1:0]        clkSel;
		logic              cle;
		logic [1:0]        capMode;
		logic              tog0;
		logic              tog1;
		logic              togCap;
		logic [2:0]        imask;
		logic [1:0]        irqEn;
		logic [15:0]       cmp0;
		logic [15:0]       cmp1;
		logic [15:0]       cap0;
		logic [15:0]       uc;
		logic [osp_pkg::PRE_W-1:0] pre;
		logic              trS1;
		logic              trS2;
		logic              trS3;
		logic              ff;
		logic [15:0]       rdata;
		logic              capIrq;
		logic              matchIrq;
		logic              runOut;
		logic [15:0]       ucOut;
	} osp_dev_t;

	osp_dev_t s_q;
	osp_dev_t s_d;

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	function automatic logic tapTick(input logic [osp_pkg::PRE_W-1:0] p,
		input logic [1:0] sel);
		case (sel)
			2'h1:    tapTick = &p[osp_pkg::TAP1_LOG2-1:0];
			2'h2:    tapTick = &p[osp_pkg::TAP2_LOG2-1:0];
			default: tapTick = &p[osp_pkg::TAP3_LOG2-1:0];
		endcase
	endfunction

	function automatic logic cmpHit(input logic t, input logic [15:0] u,
		input logic [15:0] r);
		cmpHit = t && u == r;
	endfunction

	// ---------------------------------------------------------
	// combinational signals
	// ---------------------------------------------------------
	logic        active;
	logic        trigRise;
	logic        tick;
	logic [15:0] ucNew;
	logic        hit0;
	logic        hit1;
	logic        ovf;
	logic        capEv;
	logic        srcCmp0;
	logic        srcCmp1;
	logic        srcOvf;
	logic        invCmp0;
	logic        invCmp1;
	logic        invCap;
	logic        inv;

	always_comb begin
		s_d = s_q;
		active = s_q.en && s_q.run;
		// ---------------------------------------------------------
		// trigger pin synchroniser and edge detect
		// ---------------------------------------------------------
		s_d.trS1 = bus.extTrig;
		s_d.trS2 = s_q.trS1;
		s_d.trS3 = s_q.trS2;
		trigRise = s_q.trS2 && !s_q.trS3;
		// ---------------------------------------------------------
		// prescaler and up counter
		// ---------------------------------------------------------
		s_d.pre = active ? s_q.pre + 1'b1 : '0;
		if (s_q.clkSel == osp_pkg::CLK_EXT) begin
			tick = active && trigRise;
		end else begin
			tick = active && tapTick(s_q.pre, s_q.clkSel);
		end
		if (s_q.cle && s_q.uc == s_q.cmp1) begin
			ucNew = '0;
		end else begin
			ucNew = s_q.uc + 16'h0001;
		end
		hit0 = cmpHit(tick, ucNew, s_q.cmp0);
		hit1 = cmpHit(tick, ucNew, s_q.cmp1);
		ovf  = tick && s_q.uc == 16'hFFFF;
		if (!active) begin
			s_d.uc = '0;
		end else if (tick) begin
			s_d.uc = ucNew;
		end
		// ---------------------------------------------------------
		// capture
		// ---------------------------------------------------------
		capEv = active && trigRise && s_q.capMode == osp_pkg::CAPM_RISE;
		if (capEv) begin
			s_d.cap0 = s_q.uc;
		end
		// ---------------------------------------------------------
		// interrupts
		// ---------------------------------------------------------
		s_d.capIrq = capEv && s_q.irqEn[osp_pkg::E_CAP];
		srcCmp1 = hit1 && !s_q.imask[osp_pkg::I_MSK1];
		srcCmp0 = hit0 && !s_q.imask[osp_pkg::I_MSK0];
		srcOvf  = ovf && !s_q.imask[osp_pkg::I_MSKOV];
		s_d.matchIrq = s_q.irqEn[osp_pkg::E_MATCH] &&
			(srcCmp1 || srcCmp0 || srcOvf);
		// ---------------------------------------------------------
		// toggle flip-flop
		// ---------------------------------------------------------
		invCmp0 = hit0 && s_q.tog0;
		invCmp1 = hit1 && s_q.tog1;
		invCap  = capEv && s_q.togCap;
		inv     = invCmp0 ^ invCmp1 ^ invCap;
		s_d.ff = s_q.ff ^ inv;
		// ---------------------------------------------------------
		// register writes
		// ---------------------------------------------------------
		if (bus.regWr) begin
			unique case (bus.regAddr)
				osp_pkg::A_ENABLE: s_d.en = bus.regWdata[0];
				osp_pkg::A_RUN:    s_d.run = bus.regWdata[0];
				osp_pkg::A_MODE: begin
					s_d.clkSel  = bus.regWdata[osp_pkg::M_CLKSEL +: 2];
					s_d.cle     = bus.regWdata[osp_pkg::M_CLE];
					s_d.capMode = bus.regWdata[osp_pkg::M_CAPM +: 2];
				end
				osp_pkg::A_TOGCTL: begin
					s_d.tog0   = bus.regWdata[osp_pkg::T_EN0];
					s_d.tog1   = bus.regWdata[osp_pkg::T_EN1];
					s_d.togCap = bus.regWdata[osp_pkg::T_ENCAP];
					unique case (bus.regWdata[osp_pkg::T_DC +: 2])
						osp_pkg::DC_INVERT: s_d.ff = !s_q.ff;
						osp_pkg::DC_SET:    s_d.ff = 1'b1;
						osp_pkg::DC_CLEAR:  s_d.ff = 1'b0;
						osp_pkg::DC_KEEP:   s_d.ff = s_q.ff ^ inv;
					endcase
				end
				osp_pkg::A_IMASK: s_d.imask = bus.regWdata[2:0];
				osp_pkg::A_IRQEN: s_d.irqEn = bus.regWdata[1:0];
				osp_pkg::A_CMP0:  s_d.cmp0 = bus.regWdata;
				osp_pkg::A_CMP1:  s_d.cmp1 = bus.regWdata;
				default: ;
			endcase
		end
		// ---------------------------------------------------------
		// register reads, answered one cycle later
		// ---------------------------------------------------------
		s_d.rdata = '0;
		if (bus.regRd) begin
			unique case (bus.regAddr)
				osp_pkg::A_ENABLE: s_d.rdata = {15'h0000, s_q.en};
				osp_pkg::A_RUN:    s_d.rdata = {15'h0000, s_q.run};
				osp_pkg::A_MODE:   s_d.rdata = {11'h000, s_q.capMode, s_q.cle, s_q.clkSel};
				osp_pkg::A_TOGCTL: s_d.rdata = {10'h000, s_q.ff, s_q.togCap,
					s_q.tog1, s_q.tog0, osp_pkg::DC_KEEP};
				osp_pkg::A_IMASK:  s_d.rdata = {13'h0000, s_q.imask};
				osp_pkg::A_IRQEN:  s_d.rdata = {14'h0000, s_q.irqEn};
				osp_pkg::A_CMP0:   s_d.rdata = s_q.cmp0;
				osp_pkg::A_CMP1:   s_d.rdata = s_q.cmp1;
				osp_pkg::A_CAP0:   s_d.rdata = s_q.cap0;
				osp_pkg::A_COUNT:  s_d.rdata = s_q.uc;
				default:           s_d.rdata = '0;
			endcase
		end
		// ---------------------------------------------------------
		// output copies
		// ---------------------------------------------------------
		s_d.runOut = s_d.en && s_d.run;
		s_d.ucOut  = s_d.uc;
	end

	// ---------------------------------------------------------
	// state register
	// ---------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.imask <= osp_pkg::IMASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------
	// outputs
	// ---------------------------------------------------------
	assign bus.regRdata = s_q.rdata;
	assign bus.capIrq   = s_q.capIrq;
	assign bus.matchIrq = s_q.matchIrq;
	assign bus.pulseOut = s_q.ff;
	assign running      = s_q.runOut;
	assign count        = s_q.ucOut;
endmodule // osp_timer

//--- osp_monitor.sv
module osp_monitor (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        regWr,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        capIrq,
	input wire logic        matchIrq,
	input wire logic        extTrig,
	input wire logic        pulseOut,
	input wire logic        running,
	input wire logic [15:0] count
);
	// ---------------------------------------------------------
	// register shadows
	// ---------------------------------------------------------
	logic [15:0] cmp0_q;
	logic [15:0] cmp1_q;
	logic [4:0]  tog_q;
	logic [4:0]  mode_q;
	logic [1:0]  irqEn_q;
	logic [2:0]  imask_q;
	logic        togWr;
	logic        hit0;
	logic        hit1;
	assign togWr = regWr && regAddr == osp_pkg::A_TOGCTL;
	assign hit0  = count == cmp0_q && tog_q[osp_pkg::T_EN0];
	assign hit1  = count == cmp1_q && tog_q[osp_pkg::T_EN1];
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmp0_q  <= 16'h0000;
			cmp1_q  <= 16'h0000;
			tog_q   <= 5'h00;
			mode_q  <= 5'h00;
			irqEn_q <= 2'h0;
			imask_q <= osp_pkg::IMASK_RST;
		end else if (regWr) begin
			case (regAddr)
				osp_pkg::A_CMP0:   cmp0_q  <= regWdata;
				osp_pkg::A_CMP1:   cmp1_q  <= regWdata;
				osp_pkg::A_TOGCTL: tog_q   <= regWdata[4:0];
				osp_pkg::A_MODE:   mode_q  <= regWdata[4:0];
				osp_pkg::A_IRQEN:  irqEn_q <= regWdata[1:0];
				osp_pkg::A_IMASK:  imask_q <= regWdata[2:0];
				default:           ;
			endcase
		end
	end
	// ---------------------------------------------------------
	// properties
	// ---------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_trigSeen;
		$rose(extTrig) && running && irqEn_q[osp_pkg::E_CAP] &&
			mode_q[4:3] == osp_pkg::CAPM_RISE;
	endsequence
	sequence s_newCount;
		running && $past(running) && $changed(count);
	endsequence
	trig_capture_a: assert property (s_trigSeen |-> ##[2:4] capIrq)
		else $error("capture interrupt missing after trigger edge");
	cap_single_a: assert property (capIrq |-> irqEn_q[osp_pkg::E_CAP] ##1 !capIrq)
		else $error("capture interrupt not a single enabled pulse");
	free_run_a: assert property (
		s_newCount ##0 !mode_q[osp_pkg::M_CLE] |-> count == $past(count) + 16'h0001)
		else $error("counter did not step by one");
	match_irq_a: assert property (
		s_newCount ##0 (count == cmp1_q && irqEn_q[1] && !imask_q[1]) |-> matchIrq)
		else $error("compare1 match interrupt missing");
	match_cause_a: assert property (
		matchIrq |-> irqEn_q[osp_pkg::E_MATCH] &&
			((count == cmp1_q && !imask_q[1]) || (count == cmp0_q && !imask_q[0]) ||
			(count == 16'h0000 && !imask_q[2])))
		else $error("match interrupt without unmasked cause");
	match_toggle_a: assert property (
		s_newCount ##0 ((hit0 != hit1) && !$past(togWr) && !capIrq) |->
			pulseOut != $past(pulseOut))
		else $error("flip-flop not inverted on match");
	no_spurious_a: assert property (
		$changed(pulseOut) |-> $past(togWr) || (capIrq && tog_q[osp_pkg::T_ENCAP]) ||
			($changed(count) && (hit0 || hit1)))
		else $error("flip-flop changed without cause");
	cap_toggle_a: assert property (
		capIrq && tog_q[osp_pkg::T_ENCAP] && !$past(togWr) |-> pulseOut != $past(pulseOut))
		else $error("flip-flop not inverted on capture");
	dc_set_a: assert property (togWr && regWdata[1:0] == osp_pkg::DC_SET |=> pulseOut)
		else $error("direct set failed");
	dc_clear_a: assert property (
		togWr && regWdata[1:0] == osp_pkg::DC_CLEAR |=> !pulseOut)
		else $error("direct clear failed");
	dc_invert_a: assert property (
		togWr && regWdata[1:0] == osp_pkg::DC_INVERT |=> pulseOut != $past(pulseOut))
		else $error("direct invert failed");
endmodule // osp_monitor

//--- oneshot_capture_pulse_test.sv
module oneshot_capture_pulse_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        rstn;
	logic        start;
	logic        withDelay;
	logic [15:0] delayCnt;
	logic [15:0] widthCnt;
	logic        trigIn;
	logic        busy;
	logic        done;
	logic        pulseSeen;
	logic        running;
	logic [15:0] count;
	int          nFail;
	int          testsRun;
	osp_if bus ();
	osp_timer u_osp_timer (.mclk(mclk), .rstn(rstn), .bus(bus.dev), .running(running),
		.count(count));
	osp_ctrl u_osp_ctrl (.mclk(mclk), .rstn(rstn), .bus(bus.host), .start(start),
		.withDelay(withDelay), .delayCnt(delayCnt), .widthCnt(widthCnt), .trigIn(trigIn),
		.busy(busy), .done(done), .pulseSeen(pulseSeen));
	osp_monitor u_osp_monitor (.mclk(mclk), .rstn(rstn), .regWr(bus.regWr),
		.regAddr(bus.regAddr), .regWdata(bus.regWdata), .capIrq(bus.capIrq),
		.matchIrq(bus.matchIrq), .extTrig(bus.extTrig), .pulseOut(bus.pulseOut),
		.running(running), .count(count));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one job: start, trigger, follow the pulse until done
	task automatic run_job(input logic wd, input logic [15:0] d, input logic [15:0] w);
		logic [15:0] capV;
		logic        rdPend;
		logic        prevOut;
		int          nEdge;
		int          k;
		@(negedge mclk);
		start = 1'b1;
		withDelay = wd;
		delayCnt = d;
		widthCnt = w;
		@(negedge mclk);
		start = 1'b0;
		repeat (8) @(negedge mclk);
		k = 0;
		while (!running && k < 50) begin
			@(negedge mclk);
			k++;
		end
		check("running", 16'h0001, {15'h0000, running});
		check("busy", 16'h0001, {15'h0000, busy});
		if (!running) begin
			complete_run();
		end
		repeat (4) @(negedge mclk);
		capV = 16'h0000;
		rdPend = 1'b0;
		prevOut = bus.pulseOut;
		nEdge = 0;
		trigIn = 1'b1;
		for (k = 0; k < 3000 && !done; k++) begin
			@(negedge mclk);
			if (k == 3) begin
				trigIn = 1'b0;
			end
			if (rdPend) begin
				capV = bus.regRdata;
			end
			rdPend = bus.regRd && bus.regAddr == osp_pkg::A_CAP0;
			if (bus.pulseOut !== prevOut) begin
				nEdge++;
				check("pulse seen", {15'h0000, prevOut}, {15'h0000, pulseSeen});
			end
			if (bus.pulseOut && !prevOut) begin
				if (wd) begin
					check("rise count", capV + d, count);
				end else begin
					check("rise on capture", 16'h0001, {15'h0000, bus.capIrq});
				end
			end
			if (!bus.pulseOut && prevOut) begin
				check("fall count", wd ? capV + d + w : capV + w, count);
				check("match irq", 16'h0001, {15'h0000, bus.matchIrq});
			end
			prevOut = bus.pulseOut;
		end
		if (!done) begin
			nFail++;
			complete_run();
		end
		repeat (200) @(negedge mclk);
		check("idle", 16'h0000, {15'h0000, busy});
		check("edges", 16'h0002, 16'(nEdge));
		check("stays low", 16'h0000, {15'h0000, bus.pulseOut});
	endtask
	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		withDelay = 1'b0;
		delayCnt = 16'h0000;
		widthCnt = 16'h0000;
		trigIn = 1'b0;
		nFail = 0;
		testsRun = 0;
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		check("pulse at reset", 16'h0000, {15'h0000, bus.pulseOut});
		trigIn = 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk);
			if (i == 3) begin
				trigIn = 1'b0;
			end
			check("no capture stopped", 16'h0000, {15'h0000, bus.capIrq});
		end
		run_job(1'b1, 16'h0028, 16'h0019);
		run_job(1'b0, 16'h0000, 16'h001E);
		run_job(1'b1, 16'h0030, 16'h0001);
		complete_run();
	end
endmodule // oneshot_capture_pulse_test
